// [hw/nlc_pkg.sv]
// constants for the no-load status and computation-mode register pair
package nlc_pkg;
    localparam logic [15:0] NLC_STATUS_ADDR  = 16'hE608;
    localparam logic [15:0] NLC_MODE_ADDR    = 16'hE60E;
    localparam logic [15:0] NLC_STATUS_RESET = 16'h0000;
    localparam logic [15:0] NLC_MODE_RESET   = 16'h01FF;
    localparam int          NLC_TOTAL_LSB    = 0;
    localparam int          NLC_FUND_LSB     = 3;
    localparam int          NLC_APP_LSB      = 6;
    localparam int          NLC_SEL1_LSB     = 0;
    localparam int          NLC_SEL2_LSB     = 3;
    localparam int          NLC_SEL3_LSB     = 6;
    localparam int          NLC_ANGLE_LSB    = 9;
    localparam int          NLC_NOM_LSB      = 11;
    localparam int          NLC_FREQ_BIT     = 14;
    localparam int          NLC_SPARE_BIT    = 15;
    localparam int          NLC_USED_MSB     = 8;

    typedef enum logic [1:0] {
        NLC_ANG_VI   = 2'h0,
        NLC_ANG_VV   = 2'h1,
        NLC_ANG_II   = 2'h2,
        NLC_ANG_NONE = 2'h3
    } nlc_angle_t;
endpackage : nlc_pkg

// [hw/nlc_idle_if.sv]
// bundle between the register core and the idle flag tracker
interface nlc_idle_if;
    logic [2:0]  total_flag;
    logic [2:0]  fund_flag;
    logic [2:0]  app_flag;
    logic [15:0] status;
    logic [2:0]  event_bits;
    modport track (
        input  total_flag, fund_flag, app_flag,
        output status, event_bits
    );
    modport core (
        output total_flag, fund_flag, app_flag,
        input  status, event_bits
    );
endinterface : nlc_idle_if

// [hw/nlc_idle_track.sv]
// per-phase idle flag tracker feeding the status word and event pulses
module nlc_idle_track #(
    parameter bit HAS_FUND = 1'b1
) (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_ce,
    nlc_idle_if.track bus
);
    import nlc_pkg::*;

    logic [2:0]  fund_gated;
    logic [15:0] status_reg;
    logic [15:0] status_next;
    logic [2:0]  event_reg;

    // variants lacking fundamental power hold these at zero
    assign fund_gated = HAS_FUND ? bus.fund_flag : 3'h0;

    always_comb begin
        status_next = NLC_STATUS_RESET;
        status_next[NLC_TOTAL_LSB +: 3] = bus.total_flag;
        status_next[NLC_FUND_LSB +: 3]  = fund_gated;
        status_next[NLC_APP_LSB +: 3]   = bus.app_flag;
    end

    // detection is the only writer of this word
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            status_reg <= NLC_STATUS_RESET;
        end else if (i_ce) begin
            status_reg <= status_next;
        end
    end

    // event fires in the same cycle as any newly set bit of its group
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            event_reg <= 3'h0;
        end else if (i_ce) begin
            event_reg[0] <= |(bus.total_flag & ~status_reg[NLC_TOTAL_LSB +: 3]);
            event_reg[1] <= |(fund_gated & ~status_reg[NLC_FUND_LSB +: 3]);
            event_reg[2] <= |(bus.app_flag & ~status_reg[NLC_APP_LSB +: 3]);
        end
    end

    assign bus.status     = status_reg;
    assign bus.event_bits = event_reg;
endmodule : nlc_idle_track

// [hw/nlc_regs.sv]
// no-load status and computation-mode registers with their steering outputs
module nlc_regs #(
    parameter bit HAS_FUND = 1'b1,
    parameter int VW       = 24
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_resetn,
    input  wire logic                  i_ce,
    input  wire logic [15:0]           i_addr,
    input  wire logic [15:0]           i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [15:0]           o_rdata,
    input  wire logic [2:0]            i_total_power_idle_flag,
    input  wire logic [2:0]            i_fundamental_power_idle_flag,
    input  wire logic [2:0]            i_apparent_power_idle_flag,
    output logic                       o_total_idle_event,
    output logic                       o_fundamental_idle_event,
    output logic                       o_apparent_idle_event,
    output logic      [2:0]            o_pulse_one_phase_select,
    output logic      [2:0]            o_pulse_two_phase_select,
    output logic      [2:0]            o_pulse_three_phase_select,
    output nlc_pkg::nlc_angle_t        o_angle_measure_select,
    output logic                       o_angle_volt_curr,
    output logic                       o_angle_volt_volt,
    output logic                       o_angle_curr_curr,
    output logic      [2:0]            o_nominal_volt_use,
    output logic                       o_line_frequency_select,
    input  wire logic [VW-1:0]         i_nominal_voltage_value,
    input  wire logic [3*VW-1:0]       i_vrms_measured,
    output logic      [3*VW-1:0]       o_vrms_used
);
    import nlc_pkg::*;

    logic [15:0]   mode_reg;
    logic [15:0]   rdata_reg;
    logic [15:0]   rdata_next;
    logic [3*VW-1:0] vrms_reg;
    logic          hit_status;
    logic          hit_mode;
    logic          mode_wr;
    nlc_angle_t    angle_sel;

    nlc_idle_if idle_bus ();

    assign idle_bus.total_flag = i_total_power_idle_flag;
    assign idle_bus.fund_flag  = i_fundamental_power_idle_flag;
    assign idle_bus.app_flag   = i_apparent_power_idle_flag;

    nlc_idle_track #(
        .HAS_FUND (HAS_FUND)
    ) u_track (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_ce     (i_ce),
        .bus      (idle_bus)
    );

    // address decode
    assign hit_status = (i_addr == NLC_STATUS_ADDR);
    assign hit_mode   = (i_addr == NLC_MODE_ADDR);
    // a write aimed at the status word is dropped here on purpose
    assign mode_wr    = i_ce && i_wr && hit_mode;

    // mode register, every bit stored so software reads back what it wrote
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mode_reg <= NLC_MODE_RESET;
        end else if (mode_wr) begin
            mode_reg <= i_wdata;
        end
    end

    // read path: one cycle later, unmapped reads give zero
    always_comb begin
        rdata_next = 16'h0000;
        if (hit_status) begin
            rdata_next = idle_bus.status;
        end else if (hit_mode) begin
            rdata_next = mode_reg;
        end
    end

    // with the clock enable high, data is held only for the cycle after the read strobe
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_reg <= 16'h0000;
        end else if (i_ce) begin
            rdata_reg <= i_rd ? rdata_next : 16'h0000;
        end
    end

    assign o_rdata = rdata_reg;

    assign o_total_idle_event       = idle_bus.event_bits[0];
    assign o_fundamental_idle_event = idle_bus.event_bits[1];
    assign o_apparent_idle_event    = idle_bus.event_bits[2];

    // phase terms feeding the three pulse outputs
    assign o_pulse_one_phase_select   = mode_reg[NLC_SEL1_LSB +: 3];
    assign o_pulse_two_phase_select   = mode_reg[NLC_SEL2_LSB +: 3];
    assign o_pulse_three_phase_select = mode_reg[NLC_SEL3_LSB +: 3];

    // angle select, decoded so the datapath needs no compare of its own
    assign angle_sel = nlc_angle_t'(mode_reg[NLC_ANGLE_LSB +: 2]);
    assign o_angle_measure_select = angle_sel;

    always_comb begin
        o_angle_volt_curr = 1'b0;
        o_angle_volt_volt = 1'b0;
        o_angle_curr_curr = 1'b0;
        case (angle_sel)
            NLC_ANG_VI: begin
                o_angle_volt_curr = 1'b1;
            end
            NLC_ANG_VV: begin
                o_angle_volt_volt = 1'b1;
            end
            NLC_ANG_II: begin
                o_angle_curr_curr = 1'b1;
            end
            default: begin
                o_angle_volt_curr = 1'b0;
            end
        endcase
    end

    assign o_nominal_volt_use = mode_reg[NLC_NOM_LSB +: 3];
    // only meaningful on fundamental-capable parts; software keeps it right
    assign o_line_frequency_select = mode_reg[NLC_FREQ_BIT];
    // spare bit 15 is stored for readback and routed nowhere

    // rms voltage seen by apparent power, nominal value overrides per phase
    genvar ph;
    generate
        for (ph = 0; ph < 3; ph++) begin : g_vrms
            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    vrms_reg[ph*VW +: VW] <= '0;
                end else if (i_ce) begin
                    if (mode_reg[NLC_NOM_LSB + ph]) begin
                        vrms_reg[ph*VW +: VW] <= i_nominal_voltage_value;
                    end else begin
                        vrms_reg[ph*VW +: VW] <= i_vrms_measured[ph*VW +: VW];
                    end
                end
            end
        end
    endgenerate

    assign o_vrms_used = vrms_reg;

    // ---------------- checks ----------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    logic          first_cycle;
    logic [3*VW-1:0] vrms_exp;

    // marks the first clock after release so reset values can be checked
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            first_cycle <= 1'b1;
        end else begin
            first_cycle <= 1'b0;
        end
    end

    always_comb begin
        vrms_exp = i_vrms_measured;
        for (int k = 0; k < 3; k++) begin
            if (mode_reg[NLC_NOM_LSB + k]) begin
                vrms_exp[k*VW +: VW] = i_nominal_voltage_value;
            end
        end
    end

    sequence s_mode_write;
        i_ce && i_wr && hit_mode;
    endsequence

    sequence s_status_write;
        i_ce && i_wr && hit_status;
    endsequence

    sequence s_read(logic hit);
        i_ce && i_rd && hit;
    endsequence

    total_flags_a: assert property (
        i_ce |=> idle_bus.status[2:0] == $past(i_total_power_idle_flag)
    ) else $error("total idle bits do not follow the flags");

    total_clear_a: assert property (
        (i_ce && i_total_power_idle_flag == 3'h0) |=> idle_bus.status[2:0] == 3'h0
    ) else $error("total idle bit set with phase loaded");

    fund_flags_a: assert property (
        i_ce |=> idle_bus.status[5:3]
            == (HAS_FUND ? $past(i_fundamental_power_idle_flag) : 3'h0)
    ) else $error("fundamental idle bits wrong");

    fund_absent_a: assert property (
        !HAS_FUND |-> idle_bus.status[5:3] == 3'h0
    ) else $error("fundamental idle bits set without fundamental support");

    app_flags_a: assert property (
        i_ce |=> idle_bus.status[8:6] == $past(i_apparent_power_idle_flag)
    ) else $error("apparent idle bits do not follow the flags");

    reserved_zero_a: assert property (
        idle_bus.status[15:9] == 7'h00
    ) else $error("reserved status bits nonzero");

    status_reset_a: assert property (
        first_cycle |-> idle_bus.status == NLC_STATUS_RESET
    ) else $error("status word not zero after reset");

    // a frozen clock enable holds the pulse, so only the first cycle is checked
    event_pair_a: assert property (
        (o_total_idle_event && $past(i_ce))
            |-> (idle_bus.status[2:0] & ~$past(idle_bus.status[2:0])) != 3'h0
    ) else $error("total idle event without a newly set bit");

    event_rise_a: assert property (
        (i_ce && (i_apparent_power_idle_flag & ~idle_bus.status[8:6]) != 3'h0)
            |=> o_apparent_idle_event
    ) else $error("apparent idle event missing on new bit");

    mode_reset_a: assert property (
        first_cycle |-> mode_reg == NLC_MODE_RESET
            && o_pulse_one_phase_select == 3'h7
            && o_angle_measure_select == NLC_ANG_VI
            && o_nominal_volt_use == 3'h0
    ) else $error("mode register reset value wrong");

    mode_write_a: assert property (
        s_mode_write |=> mode_reg == $past(i_wdata)
            && o_pulse_two_phase_select == $past(i_wdata[5:3])
            && o_pulse_three_phase_select == $past(i_wdata[8:6])
    ) else $error("mode write not applied");

    status_ro_a: assert property (
        s_status_write ##0 (i_total_power_idle_flag == 3'h0)
            |=> idle_bus.status[2:0] == 3'h0
    ) else $error("host write reached the status word");

    read_mode_a: assert property (
        s_read(hit_mode) |=> o_rdata == $past(mode_reg)
    ) else $error("mode readback wrong");

    read_status_a: assert property (
        s_read(hit_status) |=> o_rdata == $past(idle_bus.status)
    ) else $error("status readback wrong");

    angle_decode_a: assert property (
        (o_angle_volt_curr == (mode_reg[NLC_ANGLE_LSB +: 2] == 2'h0))
            && (o_angle_volt_volt == (mode_reg[NLC_ANGLE_LSB +: 2] == 2'h1))
            && (o_angle_curr_curr == (mode_reg[NLC_ANGLE_LSB +: 2] == 2'h2))
    ) else $error("angle select decode wrong");

    nominal_mux_a: assert property (
        i_ce |=> o_vrms_used == $past(vrms_exp)
    ) else $error("rms voltage source wrong");

    freeze_a: assert property (
        !i_ce |=> $stable(mode_reg) && $stable(idle_bus.status) && $stable(o_vrms_used)
    ) else $error("state moved with clock enable low");

    freq_bit_a: assert property (
        o_line_frequency_select == mode_reg[NLC_FREQ_BIT]
    ) else $error("line frequency select not from mode bit");

    // phase A rms source after a mode write, checked without the mux model
    sequence s_nom_a_set;
        s_mode_write ##0 i_wdata[NLC_NOM_LSB] ##1 i_ce;
    endsequence

    sequence s_nom_a_clear;
        s_mode_write ##0 !i_wdata[NLC_NOM_LSB] ##1 i_ce;
    endsequence

    pulse_reset_a: assert property (
        first_cycle |-> o_pulse_two_phase_select == 3'h7
            && o_pulse_three_phase_select == 3'h7
    ) else $error("pulse two or three select reset value wrong");

    spare_reset_a: assert property (
        first_cycle |-> !mode_reg[NLC_SPARE_BIT] && !o_line_frequency_select
    ) else $error("spare or frequency bit not clear after reset");

    // event pulses must follow every newly entered idle phase
    total_event_a: assert property (
        (i_ce && (i_total_power_idle_flag & ~idle_bus.status[2:0]) != 3'h0)
            |=> o_total_idle_event
    ) else $error("total idle event missing on new bit");

    fund_event_a: assert property (
        (i_ce && HAS_FUND
            && (i_fundamental_power_idle_flag & ~idle_bus.status[5:3]) != 3'h0)
            |=> o_fundamental_idle_event
    ) else $error("fundamental idle event missing on new bit");

    fund_event_off_a: assert property (
        !HAS_FUND |-> !o_fundamental_idle_event
    ) else $error("fundamental idle event without fundamental support");

    fund_pair_a: assert property (
        (o_fundamental_idle_event && $past(i_ce))
            |-> (idle_bus.status[5:3] & ~$past(idle_bus.status[5:3])) != 3'h0
    ) else $error("fundamental idle event without a newly set bit");

    app_pair_a: assert property (
        (o_apparent_idle_event && $past(i_ce))
            |-> (idle_bus.status[8:6] & ~$past(idle_bus.status[8:6])) != 3'h0
    ) else $error("apparent idle event without a newly set bit");

    app_clear_a: assert property (
        (i_ce && i_apparent_power_idle_flag == 3'h0) |=> idle_bus.status[8:6] == 3'h0
    ) else $error("apparent idle bit set with phase loaded");

    // status or unmapped writes must leave the mode word untouched
    mode_hold_a: assert property (
        !(i_ce && i_wr && hit_mode) |=> $stable(mode_reg)
    ) else $error("mode register moved without a mode write");

    select_write_a: assert property (
        s_mode_write |=> o_pulse_one_phase_select == $past(i_wdata[2:0])
            && o_nominal_volt_use == $past(i_wdata[13:11])
    ) else $error("pulse one select or nominal enables not written");

    freq_write_a: assert property (
        s_mode_write |=> o_line_frequency_select == $past(i_wdata[NLC_FREQ_BIT])
    ) else $error("line frequency select not written");

    nominal_on_a: assert property (
        s_nom_a_set |=> o_vrms_used[VW-1:0] == $past(i_nominal_voltage_value)
    ) else $error("phase A rms not replaced by nominal value");

    nominal_off_a: assert property (
        s_nom_a_clear |=> o_vrms_used[VW-1:0] == $past(i_vrms_measured[VW-1:0])
    ) else $error("phase A rms not taken from measurement");
endmodule : nlc_regs

// [sim/nlc_regs_test.sv]
// self-checking bench for the no-load status and computation-mode registers
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end

module nlc_regs_test import nlc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int             VW    = 24;
    localparam int             LIMIT = 3000;
    localparam logic [VW-1:0]  NOMV  = 24'h5A5A5A;
    localparam logic [VW-1:0]  MEAS_A = 24'hA0A0A1;
    localparam logic [VW-1:0]  MEAS_B = 24'hB0B0B2;
    localparam logic [VW-1:0]  MEAS_C = 24'hC0C0C3;

    logic             i_clk    = 1'b0;
    logic             i_resetn = 1'b0;
    logic             i_ce     = 1'b1;
    logic             i_wr     = 1'b0;
    logic             i_rd     = 1'b0;
    logic [15:0]      i_addr   = 16'h0000;
    logic [15:0]      i_wdata  = 16'h0000;
    logic [2:0]       tot      = 3'h0;
    logic [2:0]       fund     = 3'h0;
    logic [2:0]       app      = 3'h0;
    wire  [15:0]      rdata;
    wire  [15:0]      rdata_nf;
    wire              ev_tot;
    wire              ev_fund;
    wire              ev_app;
    wire              ev_fund_nf;
    wire  [2:0]       sel1;
    wire  [2:0]       sel2;
    wire  [2:0]       sel3;
    wire  [2:0]       nom_use;
    nlc_angle_t       angle;
    wire              a_vc;
    wire              a_vv;
    wire              a_cc;
    wire              freq;
    wire  [3*VW-1:0]  vused;
    logic [15:0]      rd_val;
    logic [15:0]      rd_nf;
    int               failures    = 0;
    int               check_count = 0;
    int               cycles      = 0;

    always #20 i_clk = ~i_clk;

    nlc_regs #(.HAS_FUND(1'b1), .VW(VW)) u_nlc_regs (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
        .i_total_power_idle_flag(tot), .i_fundamental_power_idle_flag(fund),
        .i_apparent_power_idle_flag(app), .o_total_idle_event(ev_tot),
        .o_fundamental_idle_event(ev_fund), .o_apparent_idle_event(ev_app),
        .o_pulse_one_phase_select(sel1), .o_pulse_two_phase_select(sel2),
        .o_pulse_three_phase_select(sel3), .o_angle_measure_select(angle),
        .o_angle_volt_curr(a_vc), .o_angle_volt_volt(a_vv), .o_angle_curr_curr(a_cc),
        .o_nominal_volt_use(nom_use), .o_line_frequency_select(freq),
        .i_nominal_voltage_value(NOMV), .i_vrms_measured({MEAS_C, MEAS_B, MEAS_A}),
        .o_vrms_used(vused));

    // variant without fundamental measurement shares every input
    nlc_regs #(.HAS_FUND(1'b0), .VW(VW)) u_nlc_regs_nofund (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata_nf),
        .i_total_power_idle_flag(tot), .i_fundamental_power_idle_flag(fund),
        .i_apparent_power_idle_flag(app), .o_total_idle_event(),
        .o_fundamental_idle_event(ev_fund_nf), .o_apparent_idle_event(),
        .o_pulse_one_phase_select(), .o_pulse_two_phase_select(),
        .o_pulse_three_phase_select(), .o_angle_measure_select(),
        .o_angle_volt_curr(), .o_angle_volt_volt(), .o_angle_curr_curr(),
        .o_nominal_volt_use(), .o_line_frequency_select(),
        .i_nominal_voltage_value(NOMV), .i_vrms_measured({MEAS_C, MEAS_B, MEAS_A}),
        .o_vrms_used());

    task automatic results();
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    // ends at the falling edge after the write edge, so outputs are settled
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(negedge i_clk);
    endtask : wr

    task automatic rd(input logic [15:0] a);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        rd_val = rdata;
        rd_nf  = rdata_nf;
    endtask : rd

    task automatic flags(input logic [2:0] t, input logic [2:0] f, input logic [2:0] p);
        @(posedge i_clk);
        tot  <= t;
        fund <= f;
        app  <= p;
        @(posedge i_clk);
        @(negedge i_clk);
    endtask : flags

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            results();
        end
    end

    initial begin
        repeat (12) @(posedge i_clk);
        i_resetn <= 1'b1;
        rd(NLC_STATUS_ADDR);
        `CHK(rd_val, 16'h0000)
        rd(NLC_MODE_ADDR);
        `CHK(rd_val, 16'h01FF)
        `CHK({sel3, sel2, sel1}, 9'h1FF)
        `CHK({nom_use, freq, angle}, 6'h00)
        flags(3'h1, 3'h0, 3'h0);
        `CHK({ev_app, ev_fund, ev_tot}, 3'h1)
        @(negedge i_clk);
        `CHK(ev_tot, 1'b0)
        rd(NLC_STATUS_ADDR);
        `CHK(rd_val, 16'h0001)
        @(negedge i_clk);
        `CHK(rdata, 16'h0000)
        // phase A leaves total idle while B and C enter it; all three enter fundamental and apparent idle
        flags(3'h6, 3'h7, 3'h7);
        `CHK({ev_app, ev_fund, ev_tot, ev_fund_nf}, 4'hE)
        rd(NLC_STATUS_ADDR);
        `CHK(rd_val, 16'h01FE)
        `CHK(rd_nf, 16'h01C6)
        wr(NLC_STATUS_ADDR, 16'hFFFF);
        rd(NLC_STATUS_ADDR);
        `CHK(rd_val, 16'h01FE)
        rd(16'hE60A);
        `CHK(rd_val, 16'h0000)
        flags(3'h0, 3'h0, 3'h0);
        rd(NLC_STATUS_ADDR);
        `CHK(rd_val, 16'h0000)
        for (int k = 0; k < 4; k++) begin
            wr(NLC_MODE_ADDR, 16'h0111 | 16'(k << 9));
            `CHK(angle, nlc_angle_t'(k))
            `CHK({a_cc, a_vv, a_vc}, 3'(1 << k))
            `CHK({sel3, sel2, sel1}, 9'h111)
        end
        wr(NLC_MODE_ADDR, 16'h1000);
        @(negedge i_clk);
        `CHK(vused, {MEAS_C, NOMV, MEAS_A})
        `CHK({nom_use, sel3, sel2, sel1}, 12'h400)
        wr(NLC_MODE_ADDR, 16'hE800);
        @(negedge i_clk);
        `CHK(vused, {NOMV, MEAS_B, NOMV})
        `CHK({freq, nom_use}, 4'hD)
        rd(NLC_MODE_ADDR);
        `CHK(rd_val, 16'hE800)
        // a strobe while the clock enable is low must not land
        @(posedge i_clk);
        i_ce <= 1'b0;
        wr(NLC_MODE_ADDR, 16'h01FF);
        @(posedge i_clk);
        i_ce <= 1'b1;
        rd(NLC_MODE_ADDR);
        `CHK(rd_val, 16'hE800)
        @(posedge i_clk);
        i_resetn <= 1'b0;
        repeat (2) @(negedge i_clk);
        `CHK({freq, nom_use, sel1}, 7'h07)
        @(posedge i_clk);
        i_resetn <= 1'b1;
        rd(NLC_MODE_ADDR);
        `CHK(rd_val, 16'h01FF)
        results();
    end
endmodule : nlc_regs_test
